// ===== hw/option_strap_decoder.sv
// Purpose: Turns latched option straps into drive controls.
// Assumes: All inputs are synchronous to mclk_i.
// Notes: Registers sit on a plain strobe port, read data one
// cycle after the read strobe.
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/100ps
module option_strap_decoder
  import strap_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = START_STEP_CYCLES,
  parameter int CNT_W = 16
)
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic force_single_ended_strap_n_i,
  input wire logic delay_start_strap_n_i,
  input wire logic motor_enable_strap_n_i,
  input wire logic write_lock_strap_n_i,
  input wire logic parity_disable_strap_n_i,
  input wire logic term_power_strap_n_i,
  input wire logic spare_strap_n_i,
  input wire logic [ID_W-1:0] bus_id_strap_n_i,
  input wire logic diff_sense_line_i,
  input wire logic power_up_done_i,
  input wire logic start_unit_i,
  input wire logic stop_unit_i,
  input wire logic write_req_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_parity_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic se_mode_o,
  output logic lvd_mode_o,
  output logic spindle_run_o,
  output logic term_power_en_o,
  output logic parity_check_en_o,
  output logic parity_err_o,
  output logic write_grant_o,
  output logic write_refuse_o,
  output logic irq_o
);
  logic [STRAP_W-1:0] pins_n;
  logic [STRAP_W-1:0] straps;
  logic straps_valid;
  logic forced_se;
  logic delay_start;
  logic motor_enable;
  logic write_lock;
  logic parity_off;
  logic term_power;
  logic [ID_W-1:0] bus_id;
  spin_state_t state;
  spin_state_t next_state;
  logic timer_start;
  logic timer_busy;
  logic timer_done;
  logic [ID_W-1:0] timer_left;
  logic cmd_start;
  logic cmd_stop;
  logic reg_wr_cmd;
  logic sense_prev;
  logic [NUM_EV-1:0] events;
  logic [NUM_EV-1:0] irq_status;
  logic [NUM_EV-1:0] irq_enable;
  logic [NUM_EV-1:0] clear_mask;
  logic [CNT_W-1:0] par_count;
  logic parity_bad;
  logic [31:0] next_rdata;

  // Gather the pins in strap word order for the latch.
  assign pins_n[FLD_FORCE_SINGLE] = force_single_ended_strap_n_i;
  assign pins_n[FLD_DELAY_START] = delay_start_strap_n_i;
  assign pins_n[FLD_MOTOR_EN] = motor_enable_strap_n_i;
  assign pins_n[FLD_WL] = write_lock_strap_n_i;
  assign pins_n[FLD_PARITY_OFF] = parity_disable_strap_n_i;
  assign pins_n[FLD_TERM_PWR] = term_power_strap_n_i;
  assign pins_n[FLD_SPARE] = spare_strap_n_i;
  assign pins_n[FLD_ID +: ID_W] = bus_id_strap_n_i;

  // One snapshot per reset keeps live jumper edits from acting.
  strap_latch #(
    .W(STRAP_W)
  ) u_latch (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .pins_n_i(pins_n),
    .fitted_o(straps),
    .valid_o(straps_valid)
  );

  // Named views of the latched straps.
  assign forced_se = straps[FLD_FORCE_SINGLE];
  assign delay_start = straps[FLD_DELAY_START];
  assign motor_enable = straps[FLD_MOTOR_EN];
  assign write_lock = straps[FLD_WL];
  assign parity_off = straps[FLD_PARITY_OFF];
  assign term_power = straps[FLD_TERM_PWR];
  assign bus_id = straps[FLD_ID +: ID_W];

  // Start and stop arrive from the command decoder or software.
  assign reg_wr_cmd = wr_i && (addr_i == OFS_CMD);
  assign cmd_start = start_unit_i || (reg_wr_cmd && wdata_i[CMD_START]);
  assign cmd_stop = stop_unit_i || (reg_wr_cmd && wdata_i[CMD_STOP]);

  // Spindle sequencing; the motor strap wins over the delay strap.
  always_comb
  begin
    next_state = state;
    timer_start = 1'b0;
    unique case (state)
      ST_POWER:
      begin
        if (straps_valid && power_up_done_i)
        begin
          if (motor_enable)
            next_state = ST_WAIT_CMD; // RQ4 RQ6
          else if (delay_start)
          begin
            next_state = ST_DELAY; // RQ5
            timer_start = 1'b1;
          end
          else
            next_state = ST_RUN; // RQ3
        end
      end
      ST_DELAY:
      begin
        if (timer_done || cmd_start)
          next_state = ST_RUN; // RQ5
      end
      ST_WAIT_CMD:
      begin
        if (cmd_start)
          next_state = ST_RUN; // RQ4 RQ6
      end
      ST_RUN:
      begin
        if (cmd_stop)
          next_state = ST_WAIT_CMD;
      end
      default:
        next_state = ST_POWER;
    endcase
  end

  // State register of the spindle sequencer.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      state <= ST_POWER;
    else
      state <= next_state;
  end

  // Bus ID times the step delay; ID zero runs out at once.
  spin_delay #(
    .STEP_CYCLES(STEP_CYCLES),
    .IDW(ID_W)
  ) u_delay (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(timer_start),
    .steps_i(bus_id),
    .busy_o(timer_busy),
    .done_o(timer_done),
    .left_o(timer_left)
  );

  // Spindle drive follows the sequencer state.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      spindle_run_o <= 1'b0;
    else
      spindle_run_o <= (next_state == ST_RUN); // RQ3 RQ5
  end

  // Transceiver mode; the sense line is live bus state, not a strap.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      se_mode_o <= 1'b1;
      lvd_mode_o <= 1'b0;
      sense_prev <= 1'b0;
    end
    else
    begin
      sense_prev <= diff_sense_line_i;
      if (forced_se)
      begin
        se_mode_o <= 1'b1; // RQ1
        lvd_mode_o <= 1'b0; // RQ1
      end
      else
      begin
        se_mode_o <= !diff_sense_line_i; // RQ2
        lvd_mode_o <= diff_sense_line_i; // RQ2
      end
    end
  end

  // Terminator power and parity enable are plain strap levels.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      term_power_en_o <= 1'b0;
      parity_check_en_o <= 1'b0;
    end
    else
    begin
      term_power_en_o <= straps_valid && term_power; // RQ10
      parity_check_en_o <= straps_valid && !parity_off; // RQ8 RQ9
    end
  end

  // Odd parity over the byte and its parity bit.
  assign parity_bad = !(^{rx_data_i, rx_parity_i});

  // Parity report pulse and running error count.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      parity_err_o <= 1'b0;
      par_count <= '0;
    end
    else
    begin
      parity_err_o <= 1'b0;
      if (rx_valid_i && parity_check_en_o && parity_bad) // RQ8 RQ9
      begin
        parity_err_o <= 1'b1; // RQ9
        if (par_count != '1)
          par_count <= par_count + 1'b1;
      end
    end
  end

  // Write requests are granted or refused with one pulse each.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      write_grant_o <= 1'b0;
      write_refuse_o <= 1'b0;
    end
    else
    begin
      write_grant_o <= write_req_i && straps_valid && !write_lock; // RQ7
      write_refuse_o <= write_req_i && (write_lock || !straps_valid); // RQ7
    end
  end

  // Events that feed the sticky status bits.
  assign events[EV_SPIN_UP] = (next_state == ST_RUN) && (state != ST_RUN);
  assign events[EV_PARITY] = rx_valid_i && parity_check_en_o && parity_bad;
  assign events[EV_WR_REFUSED] = write_req_i &&
                                 (write_lock || !straps_valid);
  assign events[EV_SENSE] = straps_valid && !forced_se &&
                            (sense_prev != diff_sense_line_i);

  // Clear mask from a write to the clear register.
  assign clear_mask = (wr_i && (addr_i == OFS_IRQ_CLEAR)) ?
                      wdata_i[NUM_EV-1:0] : '0;

  // Sticky status; a new event beats a clear in the same cycle.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_status <= IRQ_STATUS_RST;
    else
      irq_status <= (irq_status & ~clear_mask) | events;
  end

  // Interrupt enable register.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_enable <= IRQ_ENABLE_RST;
    else if (wr_i && (addr_i == OFS_IRQ_ENABLE))
      irq_enable <= wdata_i[NUM_EV-1:0];
  end

  // Level interrupt, one cycle behind the status it reflects.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_status & irq_enable);
  end

  // Read mux; unmapped and write-only addresses read as zero.
  always_comb
  begin
    next_rdata = 32'h0;
    unique case (addr_i)
      OFS_STRAPS:
        next_rdata[STRAP_W-1:0] = straps;
      OFS_MODE:
      begin
        next_rdata[3:0] = state;
        next_rdata[4] = timer_busy;
        next_rdata[5] = se_mode_o;
        next_rdata[6] = lvd_mode_o;
        next_rdata[7] = spindle_run_o;
        next_rdata[8] = straps_valid;
        next_rdata[12 +: ID_W] = timer_left;
      end
      OFS_IRQ_STATUS:
        next_rdata[NUM_EV-1:0] = irq_status;
      OFS_IRQ_ENABLE:
        next_rdata[NUM_EV-1:0] = irq_enable;
      OFS_PAR_COUNT:
        next_rdata[CNT_W-1:0] = par_count;
      default:
        next_rdata = 32'h0;
    endcase
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 32'h0;
    else if (rd_i)
      rdata_o <= next_rdata;
    else
      rdata_o <= 32'h0;
  end
endmodule

// ===== hw/strap_pkg.sv
// Purpose: Shared constants for the option strap decoder.
// Assumes: A 40 MHz clock and 32-bit register words.
// Notes: A strap pin reads low when its jumper is fitted.
// Summary of operation
// RQ1 - Forced strap makes transceivers single-ended only; code takes sense line on the first edge after reset.
// RQ2 - Otherwise sense line picks differential or single-ended.
// RQ3 - No start straps: spin up after power-up.
// RQ4 - Motor strap alone: wait for Start Unit.
// RQ5 - Delay strap alone: wait ID times 12 s.
// RQ6 - Both straps: Start Unit, delay ignored.
// RQ7 - Write-lock strap refuses every medium write.
// RQ8 - Parity strap: no parity check, no report.
// RQ9 - Default: check parity and report result.
// RQ10 - Terminator power only with its strap fitted.
// RQ11 - Strap changes wait for the next power cycle.
// RQ12 - Fitted jumper reads asserted, open reads deasserted.
// RQ13 - Straps latched once at reset release.
package strap_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned START_STEP_S = 12;
  localparam int unsigned START_STEP_CYCLES = START_STEP_S * CLK_HZ;
  // Register byte addresses.
  localparam logic [7:0] OFS_STRAPS = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h10;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
  localparam logic [7:0] OFS_PAR_COUNT = 8'h18;
  // Positions in the latched strap word.
  localparam int FLD_FORCE_SINGLE = 0;
  localparam int FLD_DELAY_START = 1;
  localparam int FLD_MOTOR_EN = 2;
  localparam int FLD_WL = 3;
  localparam int FLD_PARITY_OFF = 4;
  localparam int FLD_TERM_PWR = 5;
  localparam int FLD_SPARE = 6;
  localparam int FLD_ID = 7;
  localparam int ID_W = 4;
  localparam int STRAP_W = FLD_ID + ID_W;
  // Command register bits.
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  // Event bits in status, clear and enable registers.
  localparam int EV_SPIN_UP = 0;
  localparam int EV_PARITY = 1;
  localparam int EV_WR_REFUSED = 2;
  localparam int EV_SENSE = 3;
  localparam int NUM_EV = 4;
  localparam logic [NUM_EV-1:0] IRQ_ENABLE_RST = 4'h0;
  localparam logic [NUM_EV-1:0] IRQ_STATUS_RST = 4'h0;
  typedef enum logic [3:0] {
    ST_POWER = 4'h1,
    ST_DELAY = 4'h2,
    ST_WAIT_CMD = 4'h4,
    ST_RUN = 4'h8
  } spin_state_t;
endpackage

// ===== hw/strap_latch.sv
// Purpose: Catches the jumper straps once after reset release.
// Assumes: Pins are steady while reset is released.
// Notes: Later pin changes are ignored until the next reset.
`timescale 1ns/100ps
module strap_latch
#(
  parameter int W = 11
)
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] pins_n_i,
  output logic [W-1:0] fitted_o,
  output logic valid_o
);
  // Takes one snapshot on the first edge after reset, then holds.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fitted_o <= '0;
      valid_o <= 1'b0;
    end
    else if (!valid_o)
    begin
      fitted_o <= ~pins_n_i; // RQ12
      valid_o <= 1'b1; // RQ13 RQ11
    end
  end
endmodule

// ===== hw/spin_delay.sv
// Purpose: Counts a number of fixed start steps.
// Assumes: start_i is a one-cycle pulse.
// Notes: Zero steps finishes on the second edge.
`timescale 1ns/100ps
module spin_delay
#(
  parameter int unsigned STEP_CYCLES = 480_000_000,
  parameter int IDW = 4
)
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [IDW-1:0] steps_i,
  output logic busy_o,
  output logic done_o,
  output logic [IDW-1:0] left_o
);
  logic [31:0] cyc;

  // Cycle counter nested inside the step counter.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      left_o <= '0;
      cyc <= 32'h0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        busy_o <= 1'b1;
        left_o <= steps_i;
        cyc <= 32'h0;
      end
      else if (busy_o)
      begin
        if (left_o == '0)
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
        else if (cyc == 32'(STEP_CYCLES - 1))
        begin
          cyc <= 32'h0;
          left_o <= left_o - 1'b1;
        end
        else
          cyc <= cyc + 32'h1;
      end
    end
  end
endmodule

// ===== verification/strap_chk.sv
// Purpose: Port assertions for the option strap decoder.
// Assumes: One clock domain, reset active high.
// Notes: The straps are caught here once, as the design does.
`timescale 1ns/100ps
module strap_chk
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic force_single_ended_strap_n_i,
  input wire logic delay_start_strap_n_i,
  input wire logic motor_enable_strap_n_i,
  input wire logic write_lock_strap_n_i,
  input wire logic parity_disable_strap_n_i,
  input wire logic term_power_strap_n_i,
  input wire logic diff_sense_line_i,
  input wire logic power_up_done_i,
  input wire logic start_unit_i,
  input wire logic wr_i,
  input wire logic write_req_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_parity_i,
  input wire logic se_mode_o,
  input wire logic lvd_mode_o,
  input wire logic spindle_run_o,
  input wire logic term_power_en_o,
  input wire logic parity_check_en_o,
  input wire logic parity_err_o,
  input wire logic write_grant_o,
  input wire logic write_refuse_o
);
  logic got;
  logic [5:0] fit;
  logic par_ok;
  // High when the received byte and its bit hold odd parity.
  assign par_ok = ^{rx_data_i, rx_parity_i};
  default clocking dclk @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  // Straps as fitted, taken at the first edge after reset.
  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      got <= 1'b0;
      fit <= 6'h0;
    end
    else if (!got)
    begin
      got <= 1'b1;
      fit <= ~{term_power_strap_n_i, parity_disable_strap_n_i,
        write_lock_strap_n_i, motor_enable_strap_n_i,
        delay_start_strap_n_i, force_single_ended_strap_n_i};
    end
  end
  se_forced_a: assert property (
    got && fit[0] |=> se_mode_o && !lvd_mode_o)
    else $error("single-ended mode not forced");
  sense_pick_a: assert property (
    got && !fit[0] |=> lvd_mode_o == $past(diff_sense_line_i)
    && se_mode_o != lvd_mode_o)
    else $error("bus mode does not follow sense line");
  spin_now_a: assert property (
    got && fit[2:1] == 2'b00 && $rose(power_up_done_i)
    |-> ##[1:4] spindle_run_o)
    else $error("spindle did not start after power-up");
  motor_hold_a: assert property (
    got && fit[2] && !spindle_run_o && !start_unit_i && !wr_i
    |=> !spindle_run_o)
    else $error("spindle started without start command");
  wr_lock_a: assert property (
    got && write_req_i |=> write_refuse_o == fit[3]
    && write_grant_o == !fit[3])
    else $error("write answer does not match lock strap");
  par_off_a: assert property (
    got && fit[4] |-> !parity_err_o)
    else $error("parity error reported while disabled");
  par_en_a: assert property (
    got |=> parity_check_en_o == !fit[4])
    else $error("parity check enable wrong");
  par_err_a: assert property (
    parity_check_en_o && rx_valid_i
    |=> parity_err_o == !$past(par_ok))
    else $error("parity error pulse wrong");
  term_pwr_a: assert property (
    got |=> term_power_en_o == fit[5])
    else $error("terminator power enable wrong");
endmodule

// ===== verification/host_model.sv
// Purpose: Host initiator model driving the bus-side pulses.
// Assumes: Every pulse is one clock long, launched after an edge.
// Notes: Idle data lines carry the inverse of the last byte.
`timescale 1ns/100ps
module host_model
(
  input wire logic mclk_i,
  output logic start_unit_o,
  output logic write_req_o,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_parity_o
);
  // Quiet bus at time zero.
  initial
  begin
    start_unit_o = 1'b0;
    write_req_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o = 8'h5a;
    rx_parity_o = 1'b0;
  end
  // One byte with odd parity, spoilt when bad is set.
  task automatic send(input logic [7:0] d, input logic bad);
    @(posedge mclk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= d;
    rx_parity_o <= ~^d ^ bad;
    @(posedge mclk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~d;
    rx_parity_o <= ^d ^ bad;
  endtask
  // Start Unit command as a one-cycle pulse.
  task automatic start;
    @(posedge mclk_i);
    start_unit_o <= 1'b1;
    @(posedge mclk_i);
    start_unit_o <= 1'b0;
  endtask
  // Medium write request as a one-cycle pulse.
  task automatic wreq;
    @(posedge mclk_i);
    write_req_o <= 1'b1;
    @(posedge mclk_i);
    write_req_o <= 1'b0;
  endtask
endmodule

// ===== verification/test_option_strap_decoder.sv
// Purpose: Self-checking bench for the option strap decoder.
// Assumes: Start step shortened to STEP cycles.
// Notes: Each boot is a fresh power cycle with new straps.
`timescale 1ns/100ps
module test_option_strap_decoder;
  import strap_pkg::*;
  localparam int unsigned STEP = 20;
  logic mclk_i, rst_i, diff_sense_line_i, power_up_done_i;
  logic wr_i, rd_i, start_unit_i, write_req_i, rx_valid_i, rx_parity_i;
  logic se_mode_o, lvd_mode_o, spindle_run_o, term_power_en_o;
  logic parity_check_en_o, parity_err_o, write_grant_o;
  logic write_refuse_o, irq_o;
  logic [10:0] pins_n;
  logic [7:0] addr_i, rx_data_i;
  logic [31:0] wdata_i, rdata_o;
  int fails, cmp_count;
  option_strap_decoder #(.STEP_CYCLES(STEP)) u_option_strap_decoder (
    .mclk_i, .rst_i, .force_single_ended_strap_n_i(pins_n[0]),
    .delay_start_strap_n_i(pins_n[1]), .motor_enable_strap_n_i(pins_n[2]),
    .write_lock_strap_n_i(pins_n[3]), .parity_disable_strap_n_i(pins_n[4]),
    .term_power_strap_n_i(pins_n[5]), .spare_strap_n_i(pins_n[6]),
    .bus_id_strap_n_i(pins_n[10:7]), .diff_sense_line_i, .power_up_done_i,
    .start_unit_i, .stop_unit_i(1'b0), .write_req_i, .rx_valid_i,
    .rx_data_i, .rx_parity_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .se_mode_o, .lvd_mode_o, .spindle_run_o, .term_power_en_o,
    .parity_check_en_o, .parity_err_o, .write_grant_o, .write_refuse_o,
    .irq_o);
  host_model u_host_model (.mclk_i, .start_unit_o(start_unit_i),
    .write_req_o(write_req_i), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i), .rx_parity_o(rx_parity_i));
  // Free-running 40 MHz clock.
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask
  // Power cycle with the given strap pins, then power-up done.
  task automatic boot(input logic [10:0] p);
    @(posedge mclk_i);
    pins_n <= p;
    rst_i <= 1'b1;
    power_up_done_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    power_up_done_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic wait_run(input int n);
    for (int i = 0; i < n && spindle_run_o !== 1'b1; i++)
    begin
      @(posedge mclk_i);
      #1;
    end
    chk(32'(spindle_run_o), 32'h1);
  endtask
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog against a hung sequence.
  initial
  begin
    repeat (5000) @(posedge mclk_i);
    fails++;
    end_sim();
  end
  // Main sequence of strap settings.
  initial
  begin
    fails = 0;
    cmp_count = 0;
    rst_i = 1'b1;
    power_up_done_i = 1'b0;
    diff_sense_line_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    boot({~4'h5, 7'h7f});
    wait_run(4);
    rd_reg(OFS_STRAPS, 32'h280);
    chk(32'({se_mode_o, lvd_mode_o}), 32'h1);
    chk(32'({term_power_en_o, parity_check_en_o}), 32'h1);
    @(posedge mclk_i);
    diff_sense_line_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 chk(32'({se_mode_o, lvd_mode_o}), 32'h2);
    u_host_model.send(8'h3c, 1'b0);
    #1 chk(32'(parity_err_o), 32'h0);
    wr_reg(OFS_IRQ_CLEAR, 32'hf);
    wr_reg(OFS_IRQ_ENABLE, 32'h2);
    rd_reg(OFS_IRQ_ENABLE, 32'h2);
    rd_reg(OFS_IRQ_STATUS, 32'h0);
    chk(32'(irq_o), 32'h0);
    u_host_model.send(8'h3c, 1'b1);
    #1 chk(32'(parity_err_o), 32'h1);
    repeat (2) @(posedge mclk_i);
    #1 chk(32'(irq_o), 32'h1);
    rd_reg(OFS_IRQ_STATUS, 32'h2);
    rd_reg(OFS_PAR_COUNT, 32'h1);
    wr_reg(OFS_IRQ_CLEAR, 32'h2);
    repeat (2) @(posedge mclk_i);
    #1 chk(32'(irq_o), 32'h0);
    rd_reg(8'h1c, 32'h0);
    u_host_model.wreq();
    #1 chk(32'(write_grant_o), 32'h1);
    @(posedge mclk_i);
    pins_n <= 11'h000;
    rd_reg(OFS_STRAPS, 32'h280);
    chk(32'(term_power_en_o), 32'h0);
    @(posedge mclk_i);
    diff_sense_line_i <= 1'b1;
    boot(11'h7c2);
    repeat (8) @(posedge mclk_i);
    #1 chk(32'(spindle_run_o), 32'h0);
    chk(32'({se_mode_o, lvd_mode_o}), 32'h2);
    chk(32'({term_power_en_o, parity_check_en_o}), 32'h2);
    rd_reg(OFS_STRAPS, 32'h03d);
    u_host_model.send(8'h3c, 1'b1);
    #1 chk(32'(parity_err_o), 32'h0);
    rd_reg(OFS_PAR_COUNT, 32'h0);
    u_host_model.wreq();
    #1 chk(32'(write_refuse_o), 32'h1);
    u_host_model.start();
    wait_run(3);
    boot(11'h67d);
    repeat (3 * STEP - 8) @(posedge mclk_i);
    #1 chk(32'(spindle_run_o), 32'h0);
    wait_run(20);
    boot(11'h7fd);
    wait_run(6);
    wr_reg(OFS_CMD, 32'h2);
    #1 chk(32'(spindle_run_o), 32'h0);
    rd_reg(OFS_MODE, 32'h144);
    wr_reg(OFS_CMD, 32'h1);
    #1 chk(32'(spindle_run_o), 32'h1);
    boot(11'h6f9);
    repeat (3 * STEP) @(posedge mclk_i);
    #1 chk(32'(spindle_run_o), 32'h0);
    u_host_model.start();
    wait_run(3);
    end_sim();
  end
endmodule
bind option_strap_decoder strap_chk u_strap_chk (.mclk_i, .rst_i,
  .force_single_ended_strap_n_i, .delay_start_strap_n_i,
  .motor_enable_strap_n_i, .write_lock_strap_n_i,
  .parity_disable_strap_n_i, .term_power_strap_n_i, .diff_sense_line_i,
  .power_up_done_i, .start_unit_i, .write_req_i, .rx_valid_i,
  .rx_data_i, .rx_parity_i, .se_mode_o, .lvd_mode_o, .spindle_run_o,
  .term_power_en_o, .parity_check_en_o, .parity_err_o, .write_grant_o,
  .write_refuse_o, .wr_i);
